//--- verilog/bsbu_pkg.sv
/*
 Package for the branch, skip and bit-operation execution unit.
 Holds opcode encodings, status flag positions, cycle counts and state codes.
 Assumes a core decode stage that has already classified each instruction.
*/
// Operation
// - Skip next instruction when chosen register bit is one; 1/2/3 cycles, flags kept.
// - I/O skip tests low I/O register bit, zero or one variant; flags kept.
// - Taken skip adds 2 or 3 to PC, by skipped instruction length.
// - Flag branch tests chosen status bit; taken loads PC+k+1 in 2 cycles.
// - Equal branch on zero flag one, not-equal on zero flag zero.
// - Carry branches on carry one (lower) or carry zero (same or higher).
// - Negative branch on N one, positive on N zero; 1 or 2 cycles.
// - Signed ge taken when N xor V is zero, signed lt when one.
// - Half-carry branches taken when H matches variant value.
// - Transfer branches taken when T matches variant value; 1 or 2 cycles.
// - Overflow branches taken on V one or zero; no flags change.
// - Interrupt-state branches taken on I one or zero.
// - I/O bit force one or zero sets addressed bit; 2 cycles, flags kept.
// - Left shift moves bits up, zero into bit 0; sets Z,C,N,V.
// - Right shift moves bits down, zero into bit 7; sets Z,C,N,V.
// - Rotates through carry: old carry enters, shifted-out bit becomes carry.
// - Nibble exchange swaps halves in one cycle, flags kept.
// - Bit store copies register bit to T; bit load copies T to bit.
`default_nettype none
package bsbu_pkg;
	// ----------------------------------------
	// Operation codes
	// ----------------------------------------
	typedef enum logic [4:0] {
		BSBU_OP_NONE                = 5'h00,
		BSBU_OP_SKIP_IF_REG_BIT_ZERO = 5'h01,
		BSBU_OP_SKIP_IF_REG_BIT_ONE = 5'h02,
		BSBU_OP_SKIP_IF_IO_BIT_ZERO = 5'h03,
		BSBU_OP_SKIP_IF_IO_BIT_ONE  = 5'h04,
		BSBU_OP_BRANCH_FLAG_ONE     = 5'h05,
		BSBU_OP_BRANCH_FLAG_ZERO    = 5'h06,
		BSBU_OP_BRANCH_SIGNED_GE    = 5'h07,
		BSBU_OP_BRANCH_SIGNED_LT    = 5'h08,
		BSBU_OP_IO_BIT_FORCE_ONE    = 5'h09,
		BSBU_OP_IO_BIT_FORCE_ZERO   = 5'h0a,
		BSBU_OP_LOGICAL_LEFT_SHIFT  = 5'h0b,
		BSBU_OP_LOGICAL_RIGHT_SHIFT = 5'h0c,
		BSBU_OP_ROTATE_LEFT_CARRY   = 5'h0d,
		BSBU_OP_ROTATE_RIGHT_CARRY  = 5'h0e,
		BSBU_OP_ARITH_RIGHT_SHIFT   = 5'h0f,
		BSBU_OP_SWAP_NIBBLES        = 5'h10,
		BSBU_OP_FLAG_FORCE_ONE      = 5'h11,
		BSBU_OP_FLAG_FORCE_ZERO     = 5'h12,
		BSBU_OP_BIT_TO_TRANSFER     = 5'h13,
		BSBU_OP_TRANSFER_TO_BIT     = 5'h14
	} bsbu_op_type;

	// ----------------------------------------
	// Status flag positions and reset value
	// ----------------------------------------
	localparam logic [2:0] BSBU_FLAG_C = 3'h0;
	localparam logic [2:0] BSBU_FLAG_Z = 3'h1;
	localparam logic [2:0] BSBU_FLAG_N = 3'h2;
	localparam logic [2:0] BSBU_FLAG_V = 3'h3;
	localparam logic [2:0] BSBU_FLAG_S = 3'h4;
	localparam logic [2:0] BSBU_FLAG_H = 3'h5;
	localparam logic [2:0] BSBU_FLAG_T = 3'h6;
	localparam logic [2:0] BSBU_FLAG_I = 3'h7;
	localparam logic [7:0] BSBU_FLAGS_RESET = 8'h00;
	localparam logic [15:0] BSBU_PC_RESET = 16'h0000;

	// ----------------------------------------
	// Cycle counts and PC steps
	// ----------------------------------------
	localparam logic [1:0] BSBU_CYC_SINGLE = 2'h1;
	localparam logic [1:0] BSBU_CYC_BRANCH = 2'h2;
	localparam logic [1:0] BSBU_CYC_IO_BIT = 2'h2;
	localparam logic [15:0] BSBU_PC_STEP = 16'h0001;
	localparam logic [15:0] BSBU_SKIP_SHORT = 16'h0002;
	localparam logic [15:0] BSBU_SKIP_LONG = 16'h0003;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		BSBU_ST_IDLE = 3'b001,
		BSBU_ST_WAIT = 3'b010,
		BSBU_ST_DONE = 3'b100
	} bsbu_state_type;
endpackage
`default_nettype wire

//--- verilog/bsbu_alu_if.sv
/*
 Interface carrying operands and results between the unit and its shifter.
 Assumes a single clock domain; purely combinational traffic.
*/
`default_nettype none
interface bsbu_alu_if;
	bsbu_pkg::bsbu_op_type op;
	logic [7:0]            operand;
	logic [7:0]            flags_in;
	logic [2:0]            bit_sel;
	logic [7:0]            result;
	logic [7:0]            flags_out;
	logic                  writes_reg;
	modport core (output op, output operand, output flags_in, output bit_sel,
		input result, input flags_out, input writes_reg);
	modport alu (input op, input operand, input flags_in, input bit_sel,
		output result, output flags_out, output writes_reg);
endinterface
`default_nettype wire

//--- verilog/bsbu_shift_alu.sv
/*
 Combinational shifter, rotate, swap and bit-transfer datapath.
 Assumes the caller registers result and flags.
*/
`default_nettype none
module bsbu_shift_alu (
	bsbu_alu_if.alu a
);
	logic [7:0] r;
	logic [7:0] f;
	logic       co;
	logic       upd;
	always_comb begin
		r = a.operand;
		f = a.flags_in;
		co = a.flags_in[bsbu_pkg::BSBU_FLAG_C];
		upd = 1'b0;
		a.writes_reg = 1'b1;
		unique case (a.op)
			bsbu_pkg::BSBU_OP_LOGICAL_LEFT_SHIFT: begin
				r = {a.operand[6:0], 1'b0};
				co = a.operand[7];
				upd = 1'b1;
			end
			bsbu_pkg::BSBU_OP_LOGICAL_RIGHT_SHIFT: begin
				r = {1'b0, a.operand[7:1]};
				co = a.operand[0];
				upd = 1'b1;
			end
			bsbu_pkg::BSBU_OP_ROTATE_LEFT_CARRY: begin
				r = {a.operand[6:0], a.flags_in[bsbu_pkg::BSBU_FLAG_C]};
				co = a.operand[7];
				upd = 1'b1;
			end
			bsbu_pkg::BSBU_OP_ROTATE_RIGHT_CARRY: begin
				r = {a.flags_in[bsbu_pkg::BSBU_FLAG_C], a.operand[7:1]};
				co = a.operand[0];
				upd = 1'b1;
			end
			bsbu_pkg::BSBU_OP_ARITH_RIGHT_SHIFT: begin
				r = {a.operand[7], a.operand[7:1]};
				co = a.operand[0];
				upd = 1'b1;
			end
			bsbu_pkg::BSBU_OP_SWAP_NIBBLES: r = {a.operand[3:0], a.operand[7:4]};
			bsbu_pkg::BSBU_OP_TRANSFER_TO_BIT: r[a.bit_sel] = a.flags_in[bsbu_pkg::BSBU_FLAG_T];
			bsbu_pkg::BSBU_OP_BIT_TO_TRANSFER: begin
				f[bsbu_pkg::BSBU_FLAG_T] = a.operand[a.bit_sel];
				a.writes_reg = 1'b0;
			end
			default: a.writes_reg = 1'b0;
		endcase
		if (upd) begin
			// Overflow after a shift is N xor C, sign flag follows N xor V
			f[bsbu_pkg::BSBU_FLAG_C] = co;
			f[bsbu_pkg::BSBU_FLAG_Z] = (r == 8'h00);
			f[bsbu_pkg::BSBU_FLAG_N] = r[7];
			f[bsbu_pkg::BSBU_FLAG_V] = r[7] ^ co;
			f[bsbu_pkg::BSBU_FLAG_S] = co;
		end
		a.result = r;
		a.flags_out = f;
	end
endmodule
`default_nettype wire

//--- verilog/bsbu_core.sv
/*
 Execution unit for skips, flag branches, I/O bit ops, shifts and flag ops.
 Assumes decode supplies one classified instruction per start pulse, the
 register operand alongside it, and the length of the following instruction.
 The I/O port answers reads combinationally and accepts a one-cycle write.
*/
`default_nettype none
module bsbu_core (
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic                  start,
	input  wire bsbu_pkg::bsbu_op_type op,
	input  wire logic [2:0]            bit_sel,
	input  wire logic [7:0]            reg_value,
	input  wire logic [4:0]            io_addr,
	input  wire logic [7:0]            io_rdata,
	input  wire logic [11:0]           offset,
	input  wire logic                  next_is_long,
	output logic                       busy,
	output logic                       done,
	output logic [15:0]                pc,
	output logic [7:0]                 status_flags,
	output logic                       reg_we,
	output logic [7:0]                 reg_wdata,
	output logic                       io_we,
	output logic [4:0]                 io_waddr,
	output logic [7:0]                 io_wdata
);
	// Every check below runs on the core clock and rests during reset
	default clocking bsbu_cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// ----------------------------------------
	// State
	// ----------------------------------------
	bsbu_pkg::bsbu_state_type state_q, state_d;
	logic [1:0]  wait_q, wait_d;
	logic [15:0] pc_q, pc_d;
	logic [7:0]  flags_q, flags_d;
	logic        done_q, done_d;
	logic        reg_we_q, reg_we_d;
	logic [7:0]  reg_wdata_q, reg_wdata_d;
	logic        io_we_q, io_we_d;
	logic [4:0]  io_waddr_q, io_waddr_d;
	logic [7:0]  io_wdata_q, io_wdata_d;
	logic        busy_q, busy_d;

	bsbu_alu_if alu_bus ();
	assign alu_bus.op = op;
	assign alu_bus.operand = reg_value;
	assign alu_bus.flags_in = flags_q;
	assign alu_bus.bit_sel = bit_sel;
	bsbu_shift_alu u_alu (
		.a (alu_bus.alu)
	);

	// ----------------------------------------
	// Condition evaluation
	// ----------------------------------------
	logic       cond;
	logic       is_skip;
	logic       is_branch;
	logic [15:0] rel_target;
	logic [15:0] skip_target;
	always_comb begin
		cond = 1'b0;
		is_skip = 1'b0;
		is_branch = 1'b0;
		unique case (op)
			bsbu_pkg::BSBU_OP_SKIP_IF_REG_BIT_ZERO: begin
				is_skip = 1'b1;
				cond = ~reg_value[bit_sel];
			end
			bsbu_pkg::BSBU_OP_SKIP_IF_REG_BIT_ONE: begin
				is_skip = 1'b1;
				cond = reg_value[bit_sel];
			end
			bsbu_pkg::BSBU_OP_SKIP_IF_IO_BIT_ZERO: begin
				is_skip = 1'b1;
				cond = ~io_rdata[bit_sel];
			end
			bsbu_pkg::BSBU_OP_SKIP_IF_IO_BIT_ONE: begin
				is_skip = 1'b1;
				cond = io_rdata[bit_sel];
			end
			// Named flag branches (equal, carry, negative, half, transfer, overflow, irq)
			// arrive decoded as flag-one or flag-zero with bit_sel picking the flag
			bsbu_pkg::BSBU_OP_BRANCH_FLAG_ONE: begin
				is_branch = 1'b1;
				cond = flags_q[bit_sel];
			end
			bsbu_pkg::BSBU_OP_BRANCH_FLAG_ZERO: begin
				is_branch = 1'b1;
				cond = ~flags_q[bit_sel];
			end
			bsbu_pkg::BSBU_OP_BRANCH_SIGNED_GE: begin
				is_branch = 1'b1;
				cond = ~(flags_q[bsbu_pkg::BSBU_FLAG_N] ^ flags_q[bsbu_pkg::BSBU_FLAG_V]);
			end
			bsbu_pkg::BSBU_OP_BRANCH_SIGNED_LT: begin
				is_branch = 1'b1;
				cond = flags_q[bsbu_pkg::BSBU_FLAG_N] ^ flags_q[bsbu_pkg::BSBU_FLAG_V];
			end
			default: cond = 1'b0;
		endcase
	end
	// Offset is sign-extended from 12 bits so one adder serves every relative form
	assign rel_target = pc_q + {{4{offset[11]}}, offset} + bsbu_pkg::BSBU_PC_STEP;
	assign skip_target = pc_q + (next_is_long ? bsbu_pkg::BSBU_SKIP_LONG : bsbu_pkg::BSBU_SKIP_SHORT);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		wait_d = wait_q;
		pc_d = pc_q;
		flags_d = flags_q;
		done_d = 1'b0;
		reg_we_d = 1'b0;
		reg_wdata_d = reg_wdata_q;
		io_we_d = 1'b0;
		io_waddr_d = io_waddr_q;
		io_wdata_d = io_wdata_q;
		unique case (state_q)
			bsbu_pkg::BSBU_ST_IDLE: begin
				if (start) begin
					pc_d = pc_q + bsbu_pkg::BSBU_PC_STEP;
					wait_d = bsbu_pkg::BSBU_CYC_SINGLE - 2'h1;
					if (is_skip && cond) begin
						pc_d = skip_target;
						// One extra cycle per word passed over
						wait_d = next_is_long ? bsbu_pkg::BSBU_CYC_BRANCH : 2'h1;
					end else if (is_branch && cond) begin
						pc_d = rel_target;
						wait_d = bsbu_pkg::BSBU_CYC_BRANCH - 2'h1;
					end else if (op == bsbu_pkg::BSBU_OP_IO_BIT_FORCE_ONE
						|| op == bsbu_pkg::BSBU_OP_IO_BIT_FORCE_ZERO) begin
						// Read-modify-write of the I/O byte in the second cycle
						io_waddr_d = io_addr;
						io_wdata_d = io_rdata;
						io_wdata_d[bit_sel] = (op == bsbu_pkg::BSBU_OP_IO_BIT_FORCE_ONE);
						io_we_d = 1'b1;
						wait_d = bsbu_pkg::BSBU_CYC_IO_BIT - 2'h1;
					end else if (op == bsbu_pkg::BSBU_OP_FLAG_FORCE_ONE) begin
						flags_d[bit_sel] = 1'b1;
					end else if (op == bsbu_pkg::BSBU_OP_FLAG_FORCE_ZERO) begin
						flags_d[bit_sel] = 1'b0;
					end else begin
						flags_d = alu_bus.flags_out;
						reg_we_d = alu_bus.writes_reg;
						reg_wdata_d = alu_bus.result;
					end
					if (wait_d == 2'h0) begin
						state_d = bsbu_pkg::BSBU_ST_DONE;
						done_d = 1'b1;
					end else begin
						state_d = bsbu_pkg::BSBU_ST_WAIT;
					end
				end
			end
			bsbu_pkg::BSBU_ST_WAIT: begin
				wait_d = wait_q - 2'h1;
				if (wait_q == 2'h1) begin
					state_d = bsbu_pkg::BSBU_ST_DONE;
					done_d = 1'b1;
				end
			end
			bsbu_pkg::BSBU_ST_DONE: begin
				state_d = bsbu_pkg::BSBU_ST_IDLE;
			end
			default: state_d = bsbu_pkg::BSBU_ST_IDLE;
		endcase
		// Taken from the next state so busy leaves the block as a flop, with no decode glitch
		busy_d = (state_d != bsbu_pkg::BSBU_ST_IDLE);
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= bsbu_pkg::BSBU_ST_IDLE;
			wait_q <= 2'h0;
			pc_q <= bsbu_pkg::BSBU_PC_RESET;
			flags_q <= bsbu_pkg::BSBU_FLAGS_RESET;
			done_q <= 1'b0;
			reg_we_q <= 1'b0;
			reg_wdata_q <= 8'h00;
			io_we_q <= 1'b0;
			io_waddr_q <= 5'h00;
			io_wdata_q <= 8'h00;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			wait_q <= wait_d;
			pc_q <= pc_d;
			flags_q <= flags_d;
			done_q <= done_d;
			reg_we_q <= reg_we_d;
			reg_wdata_q <= reg_wdata_d;
			io_we_q <= io_we_d;
			io_waddr_q <= io_waddr_d;
			io_wdata_q <= io_wdata_d;
			busy_q <= busy_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign busy = busy_q;
	assign done = done_q;
	assign pc = pc_q;
	assign status_flags = flags_q;
	assign reg_we = reg_we_q;
	assign reg_wdata = reg_wdata_q;
	assign io_we = io_we_q;
	assign io_waddr = io_waddr_q;
	assign io_wdata = io_wdata_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_taken_branch;
		start && state_q == bsbu_pkg::BSBU_ST_IDLE && is_branch && cond;
	endsequence
	sequence s_taken_skip;
		start && state_q == bsbu_pkg::BSBU_ST_IDLE && is_skip && cond;
	endsequence
	a_branch_target: assert property (@(posedge core_clk) disable iff (reset)
		s_taken_branch |=> pc_q == $past(rel_target)) else $error("branch target wrong");
	a_branch_two_cycles: assert property (@(posedge core_clk) disable iff (reset)
		s_taken_branch |=> !done_q ##1 done_q) else $error("taken branch not two cycles");
	a_skip_step: assert property (@(posedge core_clk) disable iff (reset)
		s_taken_skip |=> pc_q == $past(pc_q) + ($past(next_is_long) ? 16'h0003 : 16'h0002))
		else $error("skip step wrong");
	a_untaken_one_cycle: assert property (@(posedge core_clk) disable iff (reset)
		start && state_q == bsbu_pkg::BSBU_ST_IDLE && is_branch && !cond |=> done_q && pc_q == $past(pc_q) + 16'h0001)
		else $error("untaken branch not one cycle");
	a_signed_ge: assert property (@(posedge core_clk) disable iff (reset)
		op == bsbu_pkg::BSBU_OP_BRANCH_SIGNED_GE |-> cond == (flags_q[3] == flags_q[2]))
		else $error("signed ge condition wrong");
	a_io_force_write: assert property (@(posedge core_clk) disable iff (reset)
		start && state_q == bsbu_pkg::BSBU_ST_IDLE && op == bsbu_pkg::BSBU_OP_IO_BIT_FORCE_ONE
		|=> io_we_q && io_wdata_q[$past(bit_sel)] && !done_q ##1 done_q) else $error("io force one wrong");
	a_skip_flags_kept: assert property (@(posedge core_clk) disable iff (reset)
		s_taken_skip |=> $stable(flags_q)) else $error("skip changed flags");
	a_lsl_carry: assert property (@(posedge core_clk) disable iff (reset)
		start && state_q == bsbu_pkg::BSBU_ST_IDLE && op == bsbu_pkg::BSBU_OP_LOGICAL_LEFT_SHIFT
		|=> flags_q[0] == $past(reg_value[7]) && reg_wdata_q[0] == 1'b0 && reg_we_q)
		else $error("left shift wrong");
	a_swap_result: assert property (@(posedge core_clk) disable iff (reset)
		start && state_q == bsbu_pkg::BSBU_ST_IDLE && op == bsbu_pkg::BSBU_OP_SWAP_NIBBLES
		|=> reg_wdata_q == {$past(reg_value[3:0]), $past(reg_value[7:4])} && $stable(flags_q))
		else $error("swap wrong");

	// ----------------------------------------
	// Skip timing, I/O tests and I/O writes
	// ----------------------------------------
	sequence s_accept;
		start && state_q == bsbu_pkg::BSBU_ST_IDLE;
	endsequence

	sequence s_untaken_skip;
		s_accept ##0 is_skip && !cond;
	endsequence

	a_short_skip_two: assert property (
		s_taken_skip ##0 !next_is_long
		|=> !done_q ##1 done_q)
		else $error("short skip not two cycles");

	a_long_skip_three: assert property (
		s_taken_skip ##0 next_is_long
		|=> !done_q ##1 !done_q ##1 done_q)
		else $error("long skip not three cycles");

	a_untaken_skip_one: assert property (
		s_untaken_skip
		|=> done_q && pc_q == $past(pc_q) + 16'h0001)
		else $error("untaken skip not one cycle");

	a_io_skip_zero: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_SKIP_IF_IO_BIT_ZERO
		|=> (pc_q == $past(pc_q) + 16'h0001) == $past(io_rdata[bit_sel]))
		else $error("io skip on zero wrong");

	a_io_skip_one: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_SKIP_IF_IO_BIT_ONE
		|=> (pc_q == $past(pc_q) + 16'h0001) == !$past(io_rdata[bit_sel]))
		else $error("io skip on one wrong");

	a_io_force_zero: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_IO_BIT_FORCE_ZERO
		|=> io_we_q && !io_wdata_q[$past(bit_sel)] && io_waddr_q == $past(io_addr))
		else $error("io force zero wrong");

	a_io_flags_kept: assert property (
		s_accept ##0 (op == bsbu_pkg::BSBU_OP_IO_BIT_FORCE_ONE
		|| op == bsbu_pkg::BSBU_OP_IO_BIT_FORCE_ZERO)
		|=> $stable(flags_q) ##1 $stable(flags_q))
		else $error("io bit op changed flags");

	// ----------------------------------------
	// Shift, bit-transfer and flag-write results
	// ----------------------------------------
	a_lsr_result: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_LOGICAL_RIGHT_SHIFT
		|=> reg_wdata_q == {1'b0, $past(reg_value[7:1])}
		&& flags_q[bsbu_pkg::BSBU_FLAG_C] == $past(reg_value[0]))
		else $error("right shift wrong");

	a_rol_result: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_ROTATE_LEFT_CARRY
		|=> reg_wdata_q == {$past(reg_value[6:0]), $past(flags_q[bsbu_pkg::BSBU_FLAG_C])}
		&& flags_q[bsbu_pkg::BSBU_FLAG_C] == $past(reg_value[7]))
		else $error("left rotate wrong");

	a_ror_result: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_ROTATE_RIGHT_CARRY
		|=> reg_wdata_q == {$past(flags_q[bsbu_pkg::BSBU_FLAG_C]), $past(reg_value[7:1])}
		&& flags_q[bsbu_pkg::BSBU_FLAG_C] == $past(reg_value[0]))
		else $error("right rotate wrong");

	a_asr_result: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_ARITH_RIGHT_SHIFT
		|=> reg_wdata_q == {$past(reg_value[7]), $past(reg_value[7:1])}
		&& flags_q[bsbu_pkg::BSBU_FLAG_C] == $past(reg_value[0]))
		else $error("arithmetic shift wrong");

	a_store_transfer: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_BIT_TO_TRANSFER
		|=> flags_q[bsbu_pkg::BSBU_FLAG_T] == $past(reg_value[bit_sel]) && !reg_we_q)
		else $error("bit store wrong");

	a_load_transfer: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_TRANSFER_TO_BIT
		|=> reg_we_q && reg_wdata_q[$past(bit_sel)] == $past(flags_q[bsbu_pkg::BSBU_FLAG_T])
		&& $stable(flags_q))
		else $error("bit load wrong");

	a_flag_force_one: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_FLAG_FORCE_ONE
		|=> flags_q[$past(bit_sel)] && done_q)
		else $error("flag set wrong");

	a_flag_force_zero: assert property (
		s_accept ##0 op == bsbu_pkg::BSBU_OP_FLAG_FORCE_ZERO
		|=> !flags_q[$past(bit_sel)] && done_q)
		else $error("flag clear wrong");
endmodule
`default_nettype wire

//--- testbench/bsbu_io_model.sv
/*
 I/O space model facing the execution unit: 32 byte-wide registers.
 Assumes one clock; reads answer combinationally, writes land on the edge with io_we.
*/
`default_nettype none
module bsbu_io_model (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic [4:0] io_addr,
	output logic [7:0]      io_rdata,
	input  wire logic       io_we,
	input  wire logic [4:0] io_waddr,
	input  wire logic [7:0] io_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [32];

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	assign io_rdata = mem[io_addr];
	// Mixed pattern so skip tests meet both bit values
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 32; i++) begin
				mem[i] <= 8'(i * 37 + 3);
			end
		end else if (io_we) begin
			mem[io_waddr] <= io_wdata;
		end
	end
endmodule
`default_nettype wire

//--- testbench/branch_skip_bit_ops_unit_tb_top.sv
/*
 Testbench for the execution unit: runs instructions one by one and checks pc, flags and writes.
 Assumes the I/O model answers reads at once and one start is taken per completed instruction.
*/
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("Error %0t: got %h expected %h", $time, g, e); end end
module branch_skip_bit_ops_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  core_clk = 1'b0;
	logic                  reset = 1'b1;
	logic                  start = 1'b0;
	bsbu_pkg::bsbu_op_type op = bsbu_pkg::BSBU_OP_NONE;
	logic [2:0]            bit_sel = 3'h0;
	logic [7:0]            reg_value = 8'h00;
	logic [4:0]            io_addr = 5'h00;
	logic [7:0]            io_rdata;
	logic [11:0]           offset = 12'h000;
	logic                  next_is_long = 1'b0;
	logic                  busy, done, reg_we, io_we;
	logic [15:0]           pc, epc, t;
	logic [7:0]            status_flags, reg_wdata, io_wdata, ef, rwd, iwd, f, old;
	logic [4:0]            io_waddr, iwa;
	logic [11:0]           k;
	logic [8:0]            r;
	logic                  rw, iw;
	int                    cyc, checks = 0, mismatches = 0;
	bsbu_pkg::bsbu_op_type sops [6] = '{bsbu_pkg::BSBU_OP_LOGICAL_LEFT_SHIFT, bsbu_pkg::BSBU_OP_LOGICAL_RIGHT_SHIFT,
		bsbu_pkg::BSBU_OP_ROTATE_LEFT_CARRY, bsbu_pkg::BSBU_OP_ROTATE_RIGHT_CARRY,
		bsbu_pkg::BSBU_OP_ARITH_RIGHT_SHIFT, bsbu_pkg::BSBU_OP_SWAP_NIBBLES};
	logic [7:0]            vals [4] = '{8'h81, 8'h00, 8'h40, 8'hfe};
	logic [4:0]            ioas [3] = '{5'h00, 5'h05, 5'h1f};

	bsbu_core dut_u (.core_clk(core_clk), .reset(reset), .start(start), .op(op), .bit_sel(bit_sel),
		.reg_value(reg_value), .io_addr(io_addr), .io_rdata(io_rdata), .offset(offset),
		.next_is_long(next_is_long), .busy(busy), .done(done), .pc(pc), .status_flags(status_flags),
		.reg_we(reg_we), .reg_wdata(reg_wdata), .io_we(io_we), .io_waddr(io_waddr), .io_wdata(io_wdata));
	bsbu_io_model io_u (.core_clk(core_clk), .reset(reset), .io_addr(io_addr), .io_rdata(io_rdata),
		.io_we(io_we), .io_waddr(io_waddr), .io_wdata(io_wdata));

	// ----------------------------------------
	// Clock, closing and watchdog
	// ----------------------------------------
	always #10 core_clk = ~core_clk;

	task automatic end_of_test();
		if (mismatches == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Whole run is under a thousand cycles; this leaves ample margin
	initial begin
		#400us;
		mismatches++;
		end_of_test();
	end

	// ----------------------------------------
	// Instruction driver and checks
	// ----------------------------------------
	task automatic run(input bsbu_pkg::bsbu_op_type o, input logic [2:0] b, input logic [7:0] rv,
		input logic [4:0] ia, input logic [11:0] kk, input logic lg);
		@(posedge core_clk);
		start <= 1'b1;
		op <= o;
		bit_sel <= b;
		reg_value <= rv;
		io_addr <= ia;
		offset <= kk;
		next_is_long <= lg;
		@(posedge core_clk);
		start <= 1'b0;
		cyc = 0;
		rw = 1'b0;
		iw = 1'b0;
		// Strobes and done stand one cycle from the taking edge on, so each cycle up to done is inspected
		do begin
			if (cyc > 0) begin
				@(posedge core_clk);
			end
			#1;
			cyc++;
			if (reg_we === 1'b1) begin
				rw = 1'b1;
				rwd = reg_wdata;
			end
			if (io_we === 1'b1) begin
				iw = 1'b1;
				iwa = io_waddr;
				iwd = io_wdata;
			end
		end while (done !== 1'b1 && cyc < 8);
	endtask

	task automatic fin(input int ec, input logic [15:0] step);
		epc = epc + step;
		`CHK(cyc, ec)
		`CHK(pc, epc)
		`CHK(status_flags, ef)
	endtask

	task automatic setf(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			run(v[i] ? bsbu_pkg::BSBU_OP_FLAG_FORCE_ONE : bsbu_pkg::BSBU_OP_FLAG_FORCE_ZERO, 3'(i), 8'h00, 5'h00,
				12'h000, 1'b0);
			ef[i] = v[i];
			fin(1, 16'h0001);
		end
	endtask

	function automatic logic [8:0] shf(input bsbu_pkg::bsbu_op_type o, input logic [7:0] d, input logic c);
		case (o)
			bsbu_pkg::BSBU_OP_LOGICAL_LEFT_SHIFT: shf = {d[7], d[6:0], 1'b0};
			bsbu_pkg::BSBU_OP_LOGICAL_RIGHT_SHIFT: shf = {d[0], 1'b0, d[7:1]};
			bsbu_pkg::BSBU_OP_ROTATE_LEFT_CARRY: shf = {d[7], d[6:0], c};
			bsbu_pkg::BSBU_OP_ROTATE_RIGHT_CARRY: shf = {d[0], c, d[7:1]};
			bsbu_pkg::BSBU_OP_ARITH_RIGHT_SHIFT: shf = {d[0], d[7], d[7:1]};
			default: shf = {c, d[3:0], d[7:4]};
		endcase
	endfunction

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		epc = 16'h0000;
		ef = 8'h00;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		`CHK(pc, 16'h0000)
		`CHK(status_flags, 8'h00)
		`CHK(busy, 1'b0)
		setf(8'hff);
		setf(8'h00);
		// Each flag alone, and each flag cleared among set ones, with extreme offsets
		for (int i = 0; i < 8; i++) begin
			for (int v = 0; v < 2; v++) begin
				f = 8'h01 << i;
				setf(v ? f : ~f);
				k = i[0] ? 12'h800 : 12'h7ff;
				t = {{4{k[11]}}, k} + 16'h0001;
				run(bsbu_pkg::BSBU_OP_BRANCH_FLAG_ONE, 3'(i), 8'h00, 5'h00, k, 1'b0);
				fin(v ? 2 : 1, v ? t : 16'h0001);
				run(bsbu_pkg::BSBU_OP_BRANCH_FLAG_ZERO, 3'(i), 8'h00, 5'h00, k, 1'b0);
				fin(v ? 1 : 2, v ? 16'h0001 : t);
			end
		end
		for (int nv = 0; nv < 4; nv++) begin
			setf({4'h0, nv[1], nv[0], 2'h0});
			run(bsbu_pkg::BSBU_OP_BRANCH_SIGNED_GE, 3'h0, 8'h00, 5'h00, 12'h010, 1'b0);
			fin((nv[0] ^ nv[1]) ? 1 : 2, (nv[0] ^ nv[1]) ? 16'h0001 : 16'h0011);
			run(bsbu_pkg::BSBU_OP_BRANCH_SIGNED_LT, 3'h0, 8'h00, 5'h00, 12'hffe, 1'b0);
			fin((nv[0] ^ nv[1]) ? 2 : 1, (nv[0] ^ nv[1]) ? 16'hffff : 16'h0001);
		end
		for (int lg = 0; lg < 2; lg++) begin
			for (int v = 0; v < 2; v++) begin
				run(bsbu_pkg::BSBU_OP_SKIP_IF_REG_BIT_ONE, 3'h5, v ? 8'h20 : 8'hdf, 5'h00, 12'h000, lg[0]);
				fin(v ? 2 + lg : 1, v ? 16'(2 + lg) : 16'h0001);
				run(bsbu_pkg::BSBU_OP_SKIP_IF_REG_BIT_ZERO, 3'h5, v ? 8'h20 : 8'hdf, 5'h00, 12'h000, lg[0]);
				fin(v ? 1 : 2 + lg, v ? 16'h0001 : 16'(2 + lg));
			end
		end
		for (int j = 0; j < 3; j++) begin
			f = io_u.mem[ioas[j]];
			run(bsbu_pkg::BSBU_OP_SKIP_IF_IO_BIT_ZERO, ioas[j][2:0], 8'h00, ioas[j], 12'h000, ioas[j][0]);
			fin(f[ioas[j][2:0]] ? 1 : 2 + ioas[j][0], f[ioas[j][2:0]] ? 16'h0001 : 16'(2 + ioas[j][0]));
			run(bsbu_pkg::BSBU_OP_SKIP_IF_IO_BIT_ONE, ioas[j][2:0], 8'h00, ioas[j], 12'h000, ioas[j][0]);
			fin(f[ioas[j][2:0]] ? 2 + ioas[j][0] : 1, f[ioas[j][2:0]] ? 16'(2 + ioas[j][0]) : 16'h0001);
		end
		for (int j = 0; j < 3; j++) begin
			for (int v = 0; v < 2; v++) begin
				old = io_u.mem[ioas[j]];
				f = 8'h01 << ioas[j][2:0];
				run(v ? bsbu_pkg::BSBU_OP_IO_BIT_FORCE_ONE : bsbu_pkg::BSBU_OP_IO_BIT_FORCE_ZERO, ioas[j][2:0], 8'h00,
					ioas[j], 12'h000, 1'b0);
				fin(2, 16'h0001);
				`CHK({iw, iwa, iwd}, {1'b1, ioas[j], v ? old | f : old & ~f})
			end
		end
		for (int s = 0; s < 6; s++) begin
			for (int j = 0; j < 4; j++) begin
				run(j[0] ? bsbu_pkg::BSBU_OP_FLAG_FORCE_ONE : bsbu_pkg::BSBU_OP_FLAG_FORCE_ZERO, 3'h0, 8'h00, 5'h00,
					12'h000, 1'b0);
				ef[0] = j[0];
				fin(1, 16'h0001);
				r = shf(sops[s], vals[j], j[0]);
				run(sops[s], 3'h0, vals[j], 5'h00, 12'h000, 1'b0);
				// Sign flag is N xor V once the shift has set both
				if (s < 5) begin
					ef[3:0] = {r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]};
					ef[4] = ef[2] ^ ef[3];
				end
				fin(1, 16'h0001);
				`CHK({rw, rwd}, {1'b1, r[7:0]})
			end
		end
		for (int b = 0; b < 8; b++) begin
			f = (8'h01 << b) ^ (b[0] ? 8'hff : 8'h00);
			run(bsbu_pkg::BSBU_OP_BIT_TO_TRANSFER, 3'(b), f, 5'h00, 12'h000, 1'b0);
			ef[6] = f[b];
			fin(1, 16'h0001);
			old = 8'ha5;
			old[b] = ef[6];
			run(bsbu_pkg::BSBU_OP_TRANSFER_TO_BIT, 3'(b), 8'ha5, 5'h00, 12'h000, 1'b0);
			fin(1, 16'h0001);
			`CHK({rw, rwd}, {1'b1, old})
		end
		end_of_test();
	end
endmodule
`undef CHK
`default_nettype wire
